// *** shared/radio_test_status_consts.svh ***
/*
 Register addresses, reset values, key values and field positions of the
 transceiver test-setting and status register bank.
 Assumes inclusion by bare name from the package and the logic files.
*/
`ifndef RADIO_TEST_STATUS_CONSTS_SVH
`define RADIO_TEST_STATUS_CONSTS_SVH

// Test-setting register addresses, consecutive from the first.
`define RTS_ADDR_SYNTH_TEST   6'h29
`define RTS_ADDR_PROD_TEST    6'h2a
`define RTS_ADDR_GAIN_TEST    6'h2b
`define RTS_ADDR_MISC_C       6'h2c
`define RTS_ADDR_MISC_B       6'h2d
`define RTS_ADDR_MISC_A       6'h2e
`define RTS_TEST_COUNT        6

// Status register addresses, reached only with the burst bit set.
`define RTS_ADDR_PART         6'h30
`define RTS_ADDR_VERSION      6'h31
`define RTS_ADDR_FREQ_EST     6'h32
`define RTS_ADDR_LINK_QUAL    6'h33
`define RTS_ADDR_SIG_STRENGTH 6'h34
`define RTS_ADDR_RADIO_STATE  6'h35

// Reset values of the test-setting registers.
`define RTS_RST_SYNTH_TEST    8'h59
`define RTS_RST_PROD_TEST     8'h7f
`define RTS_RST_GAIN_TEST     8'h3f
`define RTS_RST_MISC_C        8'h88
`define RTS_RST_MISC_B        8'h31
`define RTS_RST_MISC_A        8'h0b

// Production test value that exposes the temperature sensor in idle.
`define RTS_TEMP_SENSOR_KEY   8'hbf

// Radio state codes used by the bank itself.
`define RTS_CODE_SLEEP        5'h00
`define RTS_CODE_IDLE         5'h01
`define RTS_CODE_CRYSTAL_OFF         5'h02
`define RTS_CODE_MANUAL_CALIBRATION_LAST  5'h05
`define RTS_CODE_WAKEUP_LAST  5'h07
`define RTS_CODE_STARTCAL     5'h08
`define RTS_CODE_SETTLE_LAST  5'h0b
`define RTS_CODE_ENDCAL       5'h0c
`define RTS_CODE_RX           5'h0d
`define RTS_CODE_RX_RST       5'h0f

// Field positions.
`define RTS_CRC_OK_BIT        7
`define RTS_ZERO_BYTE         8'h00
`define RTS_ZERO_TOP3         3'h0

`endif

// *** shared/radio_test_status_pkg.sv ***
/*
 Types shared by the test-setting and status register bank.
 Assumes the constants header sits beside it on the include path.
*/
package radio_test_status_pkg;
   `include "radio_test_status_consts.svh"

   typedef logic [7:0] reg_byte_t;
   typedef logic [5:0] reg_addr_t;
   typedef logic [4:0] radio_code_t;

   // Coarse grouping of the radio state codes.
   typedef enum logic [3:0] {
      grp_sleep,
      grp_idle,
      grp_crystal_off,
      grp_manual_calibration,
      grp_synthesizer_wakeup,
      grp_calibrate,
      grp_settling,
      grp_receive,
      grp_other
   } radio_group_e;
endpackage : radio_test_status_pkg

// *** logic/link_quality_tracker.sv ***
/*
 Holds the link quality status byte: checksum-match flag and quality value.
 Assumes one-cycle strobes from the packet logic on the same clock.
*/
`timescale 1ns/1ps
`include "radio_test_status_consts.svh"
module link_quality_tracker
   import radio_test_status_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Receive events.
   input  wire logic       rx_start_in,
   input  wire logic       crc_check_done_in,
   input  wire logic       crc_match_in,
   input  wire logic       link_quality_valid_in,
   input  wire logic [6:0] link_quality_value_in,
   // Status byte.
   output reg_byte_t       link_quality_status_out
);
   logic       crc_ok_r;
   logic       crc_ok_nxt;
   logic [6:0] quality_r;

   // A result landing in the same cycle as a receive restart wins, so it is never lost.
   assign crc_ok_nxt = crc_check_done_in ? crc_match_in :
                       rx_start_in       ? 1'b0 : crc_ok_r;

   // Flag and quality value.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         crc_ok_r  <= 1'b0;
         quality_r <= 7'h00;
      end
      else
      begin
         crc_ok_r <= crc_ok_nxt;
         if (link_quality_valid_in)
            quality_r <= link_quality_value_in;
      end
   end

   assign link_quality_status_out = {crc_ok_r, quality_r};

   a_crc_restart_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      rx_start_in && !crc_check_done_in |=> !link_quality_status_out[`RTS_CRC_OK_BIT])
      else $error("checksum flag not cleared on receive start");
   a_crc_match_set: assert property (@(posedge clk_in) disable iff (rst_in)
      crc_check_done_in && crc_match_in |=> link_quality_status_out[`RTS_CRC_OK_BIT])
      else $error("checksum flag not set on match");
   a_crc_miss_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      crc_check_done_in && !crc_match_in |=> !link_quality_status_out[`RTS_CRC_OK_BIT])
      else $error("checksum flag not cleared on mismatch");
endmodule : link_quality_tracker

// *** logic/radio_test_status_regs.sv ***
/*
 Test-setting and read-only status register bank of the transceiver,
 reached through the serial register port's decoded access strobes.
 Assumes the serial front end presents address, burst bit, one-cycle read
 and write strobes and write data on clk_in, and that the radio, modem and
 packet logic drive the status inputs on the same clock.
*/
`timescale 1ns/1ps
`include "radio_test_status_consts.svh"
module radio_test_status_regs
   import radio_test_status_pkg::*;
#(
   parameter reg_byte_t PART_ID    = 8'h5a,  // Arbitrary value.
   parameter reg_byte_t VERSION_ID = 8'h21   // Arbitrary value.
)
(
   // Clock and reset.
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Register access from the serial front end.
   input  wire logic [5:0] access_addr_in,
   input  wire logic       access_burst_in,
   input  wire logic       access_write_in,
   input  wire logic       access_read_in,
   input  wire logic [7:0] access_wdata_in,
   output reg_byte_t       access_rdata_out,
   output logic            access_rvalid_out,
   // Status sources.
   input  wire logic [4:0] radio_state_code_in,
   input  wire logic [7:0] carrier_offset_value_in,
   input  wire logic       amplitude_keying_in,
   input  wire logic       crc_check_done_in,
   input  wire logic       crc_match_in,
   input  wire logic       link_quality_valid_in,
   input  wire logic [6:0] link_quality_value_in,
   input  wire logic [7:0] signal_strength_in,
   // Test settings toward the analog and modem blocks.
   output reg_byte_t       synth_test_setting_out,
   output reg_byte_t       production_test_setting_out,
   output reg_byte_t       gain_control_test_setting_out,
   output reg_byte_t       misc_test_setting_c_out,
   output reg_byte_t       misc_test_setting_b_out,
   output reg_byte_t       misc_test_setting_a_out,
   output logic            temp_sensor_idle_en_out
);
   // Groups a radio state code; used for the current and the previous code.
   function automatic radio_group_e group_of(input radio_code_t code);
      if (code == `RTS_CODE_SLEEP)
         group_of = grp_sleep;
      else if (code == `RTS_CODE_IDLE)
         group_of = grp_idle;
      else if (code == `RTS_CODE_CRYSTAL_OFF)
         group_of = grp_crystal_off;
      else if (code <= `RTS_CODE_MANUAL_CALIBRATION_LAST)
         group_of = grp_manual_calibration;
      else if (code <= `RTS_CODE_WAKEUP_LAST)
         group_of = grp_synthesizer_wakeup;
      else if (code == `RTS_CODE_STARTCAL || code == `RTS_CODE_ENDCAL)
         group_of = grp_calibrate;
      else if (code <= `RTS_CODE_SETTLE_LAST)
         group_of = grp_settling;
      else if (code <= `RTS_CODE_RX_RST)
         group_of = grp_receive;
      else
         group_of = grp_other;
   endfunction : group_of

   // Reset value of a test-setting register by its index.
   function automatic reg_byte_t test_reset(input int idx);
      case (idx)
         0:       test_reset = `RTS_RST_SYNTH_TEST;
         1:       test_reset = `RTS_RST_PROD_TEST;
         2:       test_reset = `RTS_RST_GAIN_TEST;
         3:       test_reset = `RTS_RST_MISC_C;
         4:       test_reset = `RTS_RST_MISC_B;
         default: test_reset = `RTS_RST_MISC_A;
      endcase
   endfunction : test_reset

   reg_byte_t   test_r [`RTS_TEST_COUNT];
   reg_byte_t   freq_est_r;
   reg_byte_t   sig_strength_r;
   radio_code_t radio_state_r;
   radio_code_t prev_state_r;
   reg_byte_t   rdata_r;
   reg_byte_t   rdata_nxt;
   logic        rvalid_r;
   logic        temp_en_r;
   reg_byte_t   link_quality_status;
   reg_addr_t   test_offset;
   logic        test_hit;
   logic        status_hit;
   logic        rx_start;
   logic        temp_en_nxt;

   // Test registers sit at consecutive addresses; the offset doubles as index.
   assign test_offset = access_addr_in - `RTS_ADDR_SYNTH_TEST;
   assign test_hit    = (access_addr_in >= `RTS_ADDR_SYNTH_TEST) &&
                        (access_addr_in <= `RTS_ADDR_MISC_A);
   // Without the burst bit these addresses are command strobes owned elsewhere.
   assign status_hit  = access_burst_in && (access_addr_in >= `RTS_ADDR_PART);

   // One flop bank per test register; only the test window is writable.
   generate
      for (genvar gi = 0; gi < `RTS_TEST_COUNT; gi++)
      begin : g_test
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
               test_r[gi] <= test_reset(gi);
            else if (access_write_in && test_hit && test_offset == reg_addr_t'(gi))
               test_r[gi] <= access_wdata_in;
         end
      end
   endgenerate

   assign synth_test_setting_out        = test_r[0];
   assign production_test_setting_out   = test_r[1];
   assign gain_control_test_setting_out = test_r[2];
   assign misc_test_setting_c_out       = test_r[3];
   assign misc_test_setting_b_out       = test_r[4];
   assign misc_test_setting_a_out       = test_r[5];

   // Receive is entered from outside the receive group, or restarted via its reset code.
   assign rx_start = ((radio_state_code_in == `RTS_CODE_RX) &&
                      (group_of(prev_state_r) != grp_receive)) ||
                     ((radio_state_code_in == `RTS_CODE_RX_RST) &&
                      (prev_state_r != `RTS_CODE_RX_RST));

   // Sensor route follows the key only while idle, so a forgotten restore cannot leak.
   assign temp_en_nxt = (test_r[1] == `RTS_TEMP_SENSOR_KEY) &&
                        (group_of(radio_state_code_in) == grp_idle);

   // Status snapshots; the access port reaches only temp_en_r, through the production test register.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         freq_est_r     <= `RTS_ZERO_BYTE;
         sig_strength_r <= `RTS_ZERO_BYTE;
         radio_state_r  <= `RTS_CODE_SLEEP;
         prev_state_r   <= `RTS_CODE_SLEEP;
         temp_en_r      <= 1'b0;
      end
      else
      begin
         freq_est_r     <= amplitude_keying_in ? `RTS_ZERO_BYTE
                                               : carrier_offset_value_in;
         sig_strength_r <= signal_strength_in;
         radio_state_r  <= radio_state_code_in;
         prev_state_r   <= radio_state_code_in;
         temp_en_r      <= temp_en_nxt;
      end
   end

   assign temp_sensor_idle_en_out = temp_en_r;

   link_quality_tracker i_link_quality_tracker (
      .clk_in                  (clk_in),
      .rst_in                  (rst_in),
      .rx_start_in             (rx_start),
      .crc_check_done_in       (crc_check_done_in),
      .crc_match_in            (crc_match_in),
      .link_quality_valid_in   (link_quality_valid_in),
      .link_quality_value_in   (link_quality_value_in),
      .link_quality_status_out (link_quality_status)
   );

   // Read selection; unmapped addresses return zero.
   assign rdata_nxt =
      test_hit ? test_r[test_offset[2:0]] :
      !status_hit ? `RTS_ZERO_BYTE :
      (access_addr_in == `RTS_ADDR_PART)         ? PART_ID :
      (access_addr_in == `RTS_ADDR_VERSION)      ? VERSION_ID :
      (access_addr_in == `RTS_ADDR_FREQ_EST)     ? freq_est_r :
      (access_addr_in == `RTS_ADDR_LINK_QUAL)    ? link_quality_status :
      (access_addr_in == `RTS_ADDR_SIG_STRENGTH) ? sig_strength_r :
      (access_addr_in == `RTS_ADDR_RADIO_STATE)  ?
         {`RTS_ZERO_TOP3, radio_state_r} : `RTS_ZERO_BYTE;

   // Read data is held until the next read so the serial shifter can take it late.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         rdata_r  <= `RTS_ZERO_BYTE;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rvalid_r <= access_read_in;
         if (access_read_in)
            rdata_r <= rdata_nxt;
      end
   end

   assign access_rdata_out  = rdata_r;
   assign access_rvalid_out = rvalid_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_status_read(logic [5:0] addr);
      access_read_in && access_burst_in && access_addr_in == addr;
   endsequence

   sequence s_keyed_idle;
      production_test_setting_out == `RTS_TEMP_SENSOR_KEY &&
      radio_state_code_in == `RTS_CODE_IDLE;
   endsequence

   a_temp_route_on: assert property (s_keyed_idle |=> temp_sensor_idle_en_out)
      else $error("sensor not routed in keyed idle");
   a_temp_route_off: assert property (
      radio_state_code_in != `RTS_CODE_IDLE |=> !temp_sensor_idle_en_out)
      else $error("sensor routed outside idle");
   a_reset_values: assert property ($fell(rst_in) |->
      misc_test_setting_c_out == `RTS_RST_MISC_C &&
      misc_test_setting_b_out == `RTS_RST_MISC_B &&
      misc_test_setting_a_out == `RTS_RST_MISC_A)
      else $error("general test registers wrong after reset");
   a_part_read: assert property (s_status_read(`RTS_ADDR_PART) |=>
      access_rvalid_out && access_rdata_out == PART_ID)
      else $error("part number read wrong");
   a_version_read: assert property (s_status_read(`RTS_ADDR_VERSION) |=>
      access_rdata_out == VERSION_ID)
      else $error("version read wrong");
   a_offset_track: assert property (!amplitude_keying_in ##1
      s_status_read(`RTS_ADDR_FREQ_EST) |=>
      access_rdata_out == $past(carrier_offset_value_in, 2))
      else $error("offset estimate not reported");
   a_offset_zero_ask: assert property (amplitude_keying_in ##1
      s_status_read(`RTS_ADDR_FREQ_EST) |=> access_rdata_out == 8'h00)
      else $error("offset not zero under amplitude keying");
   a_quality_value: assert property (link_quality_valid_in ##1
      (s_status_read(`RTS_ADDR_LINK_QUAL) && !link_quality_valid_in) |=>
      access_rdata_out[6:0] == $past(link_quality_value_in, 2))
      else $error("quality value not reported");
   a_strength_read: assert property (s_status_read(`RTS_ADDR_SIG_STRENGTH) |=>
      access_rdata_out == $past(signal_strength_in, 2))
      else $error("signal strength read wrong");
   a_state_read: assert property (s_status_read(`RTS_ADDR_RADIO_STATE) |=>
      access_rdata_out[7:5] == 3'h0 &&
      access_rdata_out[4:0] == $past(radio_state_code_in, 2))
      else $error("radio state read wrong");
   a_status_write_ignored: assert property (
      access_write_in && access_addr_in >= `RTS_ADDR_PART |=>
      $stable(synth_test_setting_out) && $stable(production_test_setting_out) &&
      $stable(misc_test_setting_a_out) && $stable(gain_control_test_setting_out) &&
      $stable(misc_test_setting_c_out) && $stable(misc_test_setting_b_out))
      else $error("status write changed a register");
endmodule : radio_test_status_regs

// *** verif/host_port_model.sv ***
/*
 Host side of the register port: drives one-cycle read and write strobes.
 Assumes the bank samples strobes on the rising edge of clk_in.
*/
`timescale 1ns/1ps
`include "radio_test_status_consts.svh"
module host_port_model
   import radio_test_status_pkg::*;
(
   // Clock.
   input  wire logic      clk_in,
   // Access toward the bank.
   output logic [5:0]     access_addr_out,
   output logic           access_burst_out,
   output logic           access_write_out,
   output logic           access_read_out,
   output logic [7:0]     access_wdata_out,
   // Answer from the bank.
   input  wire reg_byte_t access_rdata_in,
   input  wire logic      access_rvalid_in
);
   // Lines start idle with no strobe raised.
   initial
   begin
      access_addr_out  = 6'h00;
      access_burst_out = 1'b0;
      access_write_out = 1'b0;
      access_read_out  = 1'b0;
      access_wdata_out = 8'h00;
   end

   // Released lines show the inverse so a stale value never passes for a live one.
   task automatic release_lines();
      access_addr_out  = ~access_addr_out;
      access_burst_out = ~access_burst_out;
      access_wdata_out = ~access_wdata_out;
   endtask : release_lines

   // The synthesizer and gain test registers are never written by this host.
   task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
      if (addr == `RTS_ADDR_SYNTH_TEST || addr == `RTS_ADDR_GAIN_TEST)
         return;
      access_addr_out  = addr;
      access_burst_out = 1'b0;
      access_wdata_out = data;
      access_write_out = 1'b1;
      @(posedge clk_in);
      #1;
      access_write_out = 1'b0;
      release_lines();
      @(posedge clk_in);
      #1;
   endtask : write_reg

   // The valid flag stands for one cycle only, so the answer is taken right after the edge.
   task automatic read_reg(input logic [5:0] addr, input logic burst, output reg_byte_t data);
      access_addr_out  = addr;
      access_burst_out = burst;
      access_read_out  = 1'b1;
      @(posedge clk_in);
      #1;
      access_read_out = 1'b0;
      release_lines();
      data = (access_rvalid_in === 1'b1) ? access_rdata_in : 8'hxx;
      @(posedge clk_in);
      #1;
   endtask : read_reg
endmodule : host_port_model

// *** verif/tb_radio_test_status_regs.sv ***
/*
 Self-checking bench for the test-setting and status register bank.
 Assumes the host model drives the register port and the bench drives status inputs.
*/
`timescale 1ns/1ps
`include "radio_test_status_consts.svh"
module tb_radio_test_status_regs
   import radio_test_status_pkg::*;
;
   localparam reg_byte_t PART = 8'h3c;  // Arbitrary value.
   localparam reg_byte_t VER  = 8'h47;  // Arbitrary value.
   logic        clk_in, rst_in, burst, wr, rd, rvalid, ask, done, match, lqv, temp_en;
   logic [5:0]  addr;
   logic [7:0]  wdata, offset, strength;
   logic [4:0]  state;
   logic [6:0]  lqval;
   reg_byte_t   rdata, syn, prod, gain, mc, mb, ma;
   int          n_mismatch, check_count, cycles;

   host_port_model i_host_port_model (.clk_in(clk_in), .access_addr_out(addr),
      .access_burst_out(burst), .access_write_out(wr), .access_read_out(rd),
      .access_wdata_out(wdata), .access_rdata_in(rdata), .access_rvalid_in(rvalid));

   radio_test_status_regs #(.PART_ID(PART), .VERSION_ID(VER)) i_radio_test_status_regs (
      .clk_in(clk_in), .rst_in(rst_in), .access_addr_in(addr), .access_burst_in(burst),
      .access_write_in(wr), .access_read_in(rd), .access_wdata_in(wdata),
      .access_rdata_out(rdata), .access_rvalid_out(rvalid), .radio_state_code_in(state),
      .carrier_offset_value_in(offset), .amplitude_keying_in(ask),
      .crc_check_done_in(done), .crc_match_in(match), .link_quality_valid_in(lqv),
      .link_quality_value_in(lqval), .signal_strength_in(strength),
      .synth_test_setting_out(syn), .production_test_setting_out(prod),
      .gain_control_test_setting_out(gain), .misc_test_setting_c_out(mc),
      .misc_test_setting_b_out(mb), .misc_test_setting_a_out(ma),
      .temp_sensor_idle_en_out(temp_en));

   // Free-running clock at 100 MHz.
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Reports and counts one comparison.
   task automatic check(input reg_byte_t seen, input reg_byte_t exp, input string msg);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic read_check(input logic [5:0] a, input logic b, input reg_byte_t exp,
                             input string msg);
      reg_byte_t d;
      i_host_port_model.read_reg(a, b, d);
      check(d, exp, msg);
   endtask : read_check

   // Status inputs are snapshotted, so a change needs one edge before a read.
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask : tick

   task automatic reset_values();
      check(syn, `RTS_RST_SYNTH_TEST, "synth out");
      check(gain, `RTS_RST_GAIN_TEST, "gain out");
      check({mc, mb, ma} == 24'h88310b ? 8'h01 : 8'h00, 8'h01, "misc outs");
      read_check(`RTS_ADDR_SYNTH_TEST, 1'b0, 8'h59, "synth rd");
      read_check(`RTS_ADDR_PROD_TEST, 1'b0, 8'h7f, "prod rd");
      read_check(`RTS_ADDR_GAIN_TEST, 1'b0, 8'h3f, "gain rd");
      read_check(`RTS_ADDR_MISC_C, 1'b0, 8'h88, "misc c rd");
      read_check(`RTS_ADDR_MISC_B, 1'b0, 8'h31, "misc b rd");
      read_check(`RTS_ADDR_MISC_A, 1'b0, 8'h0b, "misc a rd");
   endtask : reset_values

   task automatic ident_and_misc();
      read_check(`RTS_ADDR_PART, 1'b1, PART, "part");
      read_check(`RTS_ADDR_VERSION, 1'b1, VER, "version");
      read_check(`RTS_ADDR_PART, 1'b0, 8'h00, "part no burst");
      i_host_port_model.write_reg(`RTS_ADDR_MISC_C, 8'ha5);
      i_host_port_model.write_reg(`RTS_ADDR_MISC_A, 8'h3c);
      check(mc, 8'ha5, "misc c out");
      read_check(`RTS_ADDR_MISC_A, 1'b0, 8'h3c, "misc a back");
      read_check(`RTS_ADDR_MISC_B, 1'b0, 8'h31, "misc b kept");
   endtask : ident_and_misc

   // The key alone must not route the sensor; only idle together with the key does.
   task automatic temp_sensor();
      state = `RTS_CODE_SLEEP;
      i_host_port_model.write_reg(`RTS_ADDR_PROD_TEST, `RTS_TEMP_SENSOR_KEY);
      check({7'h00, temp_en}, 8'h00, "temp off in sleep");
      state = `RTS_CODE_IDLE;
      tick();
      check({7'h00, temp_en}, 8'h01, "temp on");
      i_host_port_model.write_reg(`RTS_ADDR_PROD_TEST, `RTS_RST_PROD_TEST);
      check({7'h00, temp_en}, 8'h00, "temp off");
      check(prod, 8'h7f, "prod restored");
   endtask : temp_sensor

   task automatic offset_est();
      offset = 8'h85;
      tick();
      read_check(`RTS_ADDR_FREQ_EST, 1'b1, 8'h85, "offset");
      ask = 1'b1;
      tick();
      read_check(`RTS_ADDR_FREQ_EST, 1'b1, 8'h00, "offset ask");
      ask = 1'b0;
   endtask : offset_est

   task automatic link_quality();
      done = 1'b1;
      match = 1'b1;
      lqv = 1'b1;
      lqval = 7'h5a;
      tick();
      done = 1'b0;
      lqv = 1'b0;
      read_check(`RTS_ADDR_LINK_QUAL, 1'b1, 8'hda, "lq match");
      state = `RTS_CODE_RX;
      tick();
      tick();
      read_check(`RTS_ADDR_LINK_QUAL, 1'b1, 8'h5a, "lq rx clear");
      done = 1'b1;
      tick();
      done = 1'b0;
      read_check(`RTS_ADDR_LINK_QUAL, 1'b1, 8'hda, "lq set in rx");
      state = `RTS_CODE_RX_RST;
      tick();
      read_check(`RTS_ADDR_LINK_QUAL, 1'b1, 8'h5a, "lq restart clear");
      done = 1'b1;
      tick();
      match = 1'b0;
      tick();
      done = 1'b0;
      read_check(`RTS_ADDR_LINK_QUAL, 1'b1, 8'h5a, "lq mismatch");
   endtask : link_quality

   task automatic strength_state_ro();
      strength = 8'hc6;
      for (int c = 0; c <= 5'h16; c++)
      begin
         state = c[4:0];
         tick();
         read_check(`RTS_ADDR_RADIO_STATE, 1'b1, {3'h0, c[4:0]}, "state");
      end
      read_check(`RTS_ADDR_SIG_STRENGTH, 1'b1, 8'hc6, "strength");
      i_host_port_model.write_reg(`RTS_ADDR_PART, 8'hff);
      i_host_port_model.write_reg(`RTS_ADDR_SIG_STRENGTH, 8'h11);
      read_check(`RTS_ADDR_PART, 1'b1, PART, "part after wr");
      read_check(`RTS_ADDR_SIG_STRENGTH, 1'b1, 8'hc6, "strength after wr");
   endtask : strength_state_ro

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // A hang is cut short well beyond the 136 or so cycles the run needs.
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   // Main sequence: reset for three cycles, then the scenarios in turn.
   initial
   begin
      rst_in = 1'b1;
      {ask, done, match, lqv} = 4'h0;
      {state, lqval, offset, strength} = 28'h0;
      repeat (3) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      reset_values();
      ident_and_misc();
      temp_sensor();
      offset_est();
      link_quality();
      strength_state_ro();
      print_verdict();
   end
endmodule : tb_radio_test_status_regs
